// ==== src/ddr_io_defs.vh ====
// Constants for the double-rate I/O register path
`ifndef DDR_IO_DEFS_VH
`define DDR_IO_DEFS_VH
`define MODE_BYPASS 2'h0
`define MODE_SINGLE 2'h1
`define MODE_DDR 2'h2
`define DIR_INPUT 2'h0
`define DIR_OUTPUT 2'h1
`define DIR_BIDIR 2'h2
`define FIFO_WIDTH 2
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define RST_LOW 1'h0
`endif

// ==== src/io_fifo.v ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module io_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // io_fifo

// ==== src/ddr_io_register_path.v ====
// Configurable pad register path: bypass, single register or double rate
// Functional notes
// - Preset forces registers high, DDR output only, not with power-up high
// - Power-up level follows power-up-high option in DDR mode without clear, preset or sync clear
// - Clock enables gate capture when exposed, DDR mode only
// - Optional inversion of outgoing DDR data, output-only direction
// - Clock inversion picks first-bit capture edge
// - Single register drives output enable
// - DDR enable delays drive half period
// - Hard or fabric capture behave identically
// - Single-ended input pad port when input used
// - Negative input pad for differential buffers
// - Output pad, plus negative when differential
// - Bidirectional pad drives and senses pin
// - Negative bidirectional pad when differential
// - Received data reaches logic via chosen mode
// - Bypass, single-register and DDR modes supported
// - Data two bits in DDR, else one
// - Async clear zero, preset one, sync clear zero
`timescale 1ns/1ps
`include "ddr_io_defs.vh"
module ddr_io_register_path #(
  parameter [1:0] DIRECTION = `DIR_BIDIR,
  parameter [1:0] REG_MODE = `MODE_DDR,
  parameter USE_ACLR = 0,
  parameter USE_ASET = 0,
  parameter USE_SCLR = 0,
  parameter POWER_UP_HIGH = 0,
  parameter USE_CLKEN = 1,
  parameter INVERT_DOUT = 0,
  parameter INVERT_INCLOCK = 0,
  parameter OE_SINGLE_REG = 0,
  parameter OE_DDR_REG = 1,
  parameter DIFFERENTIAL = 1,
  parameter HARD_INPUT_REG = 0
) (
  input wire I_REF_CLK,
  input wire I_RSTN,
  input wire I_PAD_IN,
  input wire I_PAD_IN_NEG,
  output reg O_PAD_OUT,
  output reg O_PAD_OUT_NEG,
  input wire I_PAD_IO,
  output reg O_PAD_IO,
  output reg O_PAD_IO_OE_N,
  input wire I_PAD_IO_NEG,
  output reg O_PAD_IO_NEG,
  output reg O_PAD_IO_NEG_OE_N,
  input wire [1:0] I_TX_DATA,
  input wire I_TX_VALID,
  output reg O_TX_READY,
  output reg [1:0] O_RX_DATA,
  input wire I_OUT_EN,
  input wire I_IN_CLKEN,
  input wire I_OUT_CLKEN,
  input wire I_ACLR,
  input wire I_ASET,
  input wire I_SCLR
);
  ////////////////////////////////////////////////////////////////////////////////
  // Configuration
  localparam DDR = (REG_MODE == `MODE_DDR);
  localparam HAS_IN = (DIRECTION != `DIR_OUTPUT);
  localparam HAS_OUT = (DIRECTION != `DIR_INPUT);
  localparam BIDIR = (DIRECTION == `DIR_BIDIR);
  localparam ASET_OK = USE_ASET && HAS_OUT && DDR && !POWER_UP_HIGH;
  localparam ACLR_OK = USE_ACLR && DDR;
  localparam SCLR_OK = USE_SCLR && DDR;
  localparam PU_HI = DDR && POWER_UP_HIGH && !USE_ACLR && !USE_ASET && !USE_SCLR;
  localparam CE_OK = USE_CLKEN && DDR;
  localparam OE_SR = OE_SINGLE_REG && !OE_DDR_REG && HAS_OUT && REG_MODE != `MODE_BYPASS;
  localparam OE_DR = OE_DDR_REG && !OE_SINGLE_REG && HAS_OUT && DDR;
  localparam INV = INVERT_DOUT && DIRECTION == `DIR_OUTPUT && DDR;
  localparam [1:0] PU = PU_HI ? 2'h3 : 2'h0;
  // Clear, preset and sync clear priority shared by the cap_q and dq_q registers
  function [1:0] ctl_next;
    input [1:0] cur;
    input [1:0] nxt;
    input en;
    input aclr;
    input aset;
    input sclr;
    begin
      if (ACLR_OK && aclr) ctl_next = 2'h0;
      else if (ASET_OK && aset) ctl_next = 2'h3;
      else if (SCLR_OK && sclr && en) ctl_next = 2'h0;
      else if (en) ctl_next = nxt;
      else ctl_next = cur;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pad and asynchronous control inputs
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= {I_ASET, I_ACLR, I_PAD_IN_NEG, I_PAD_IO, I_PAD_IN};
      s2_q <= s1_q;
    end
  end
  wire aclr_s = s2_q[3];
  wire aset_s = s2_q[4];
  // Input level taken from the positive leg only: I_PAD_IO when bidirectional, else I_PAD_IN
  wire pin_raw = BIDIR ? s2_q[1] : s2_q[0];
  wire pin_lvl = (DIFFERENTIAL && !BIDIR) ? (s2_q[0] & ~s2_q[2]) | (s2_q[0] & s2_q[2] & pin_raw)
                                          : pin_raw;
  ////////////////////////////////////////////////////////////////////////////////
  // Half-rate phase: enable pulse marks high phase of the pad clock
  reg phase_q;
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end
  wire first_slot = INVERT_INCLOCK ? phase_q : ~phase_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Input path: same logic for hard and fabric placement
  reg [1:0] cap_q;
  reg [1:0] rx_d;
  wire in_en = CE_OK ? I_IN_CLKEN : 1'b1;
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      cap_q <= PU;
    end else if (DDR) begin
      cap_q <= ctl_next(cap_q, first_slot ? {cap_q[1], pin_lvl} : {pin_lvl, cap_q[0]},
                        in_en, aclr_s, aset_s, I_SCLR);
    end
  end
  always @* begin
    rx_d = 2'h0;
    if (HAS_IN) begin
      if (DDR) rx_d = cap_q;
      else rx_d = {1'b0, pin_lvl};
    end
  end
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_RX_DATA <= PU;
    end else if (!DDR || !first_slot) begin
      O_RX_DATA <= rx_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Output data FIFO, one word drained per pad clock period in DDR mode, per reference clock otherwise
  wire [1:0] f_data;
  wire f_valid;
  wire f_in_ready;
  wire out_en = CE_OK ? I_OUT_CLKEN : 1'b1;
  wire slot_done = DDR ? phase_q : 1'b1;
  wire f_pop = HAS_OUT && out_en && slot_done;
  io_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(I_REF_CLK),
    .rst_n(I_RSTN),
    .in_data(I_TX_DATA),
    .in_valid(I_TX_VALID),
    .in_ready(f_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_TX_READY <= 1'b0;
    end else begin
      O_TX_READY <= f_in_ready;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Output data and enable registers
  reg [1:0] dq_q;
  reg oe_q;
  reg oe_late_q;
  wire [1:0] word = INV ? ~f_data : f_data;
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      dq_q <= PU;
      oe_q <= 1'b0;
      oe_late_q <= 1'b0;
    end else begin
      if (f_pop && f_valid) begin
        dq_q <= ctl_next(dq_q, DDR ? word : {word[0], word[0]}, 1'b1, aclr_s, aset_s, I_SCLR);
      end else begin
        dq_q <= ctl_next(dq_q, dq_q, 1'b0, aclr_s, aset_s, I_SCLR);
      end
      if (out_en) begin
        oe_q <= I_OUT_EN;
      end
      oe_late_q <= oe_q;
    end
  end
  // First bit (dq_q[1]) in low phase, second (dq_q[0]) in high phase
  wire bit_now = DDR ? (phase_q ? dq_q[0] : dq_q[1]) : dq_q[0];
  wire d_now = (REG_MODE == `MODE_BYPASS) ? I_TX_DATA[0] : bit_now;
  wire oe_raw = (DIRECTION == `DIR_OUTPUT) ? 1'b1 : I_OUT_EN;
  wire oe_now = OE_DR ? (oe_q & oe_late_q) : (OE_SR ? oe_q : oe_raw);
  always @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_PAD_OUT <= `RST_LOW;
      O_PAD_OUT_NEG <= `RST_LOW;
      O_PAD_IO <= `RST_LOW;
      O_PAD_IO_OE_N <= 1'b1;
      O_PAD_IO_NEG <= `RST_LOW;
      O_PAD_IO_NEG_OE_N <= 1'b1;
    end else begin
      O_PAD_OUT <= (HAS_OUT && !BIDIR) ? d_now : 1'b0;
      O_PAD_OUT_NEG <= (HAS_OUT && !BIDIR && DIFFERENTIAL) ? ~d_now : 1'b0;
      O_PAD_IO <= BIDIR ? d_now : 1'b0;
      O_PAD_IO_OE_N <= BIDIR ? ~oe_now : 1'b1;
      O_PAD_IO_NEG <= (BIDIR && DIFFERENTIAL) ? ~d_now : 1'b0;
      O_PAD_IO_NEG_OE_N <= (BIDIR && DIFFERENTIAL) ? ~oe_now : 1'b1;
    end
  end
endmodule // ddr_io_register_path

// ==== tb/pad_partner.sv ====
// Pin-side model of the bidirectional differential pad
`timescale 1ns/1ps
module pad_partner (
  input wire logic i_drv_oe_n,
  input wire logic i_drv_val,
  input wire logic i_ext_en,
  input wire logic i_ext_val,
  output logic o_line,
  output logic o_line_n
);
  // Device drive wins; released and undriven line shows the inverse of the device data value
  always_comb begin
    o_line = !i_drv_oe_n ? i_drv_val : (i_ext_en ? i_ext_val : ~i_drv_val);
    o_line_n = ~o_line;
  end
endmodule // pad_partner

// ==== tb/ddr_io_register_path_asserts.sv ====
// Concurrent checks on the pad register path ports
`timescale 1ns/1ps
module ddr_io_register_path_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_OUT_EN,
  input wire logic I_IN_CLKEN,
  input wire logic I_TX_VALID,
  input wire logic O_TX_READY,
  input wire logic O_PAD_IO,
  input wire logic O_PAD_IO_OE_N,
  input wire logic O_PAD_IO_NEG,
  input wire logic O_PAD_IO_NEG_OE_N,
  input wire logic [1:0] O_RX_DATA
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  ////////////////////////////////////////////////////////////////
  oe_reset_a: assert property (disable iff (1'b0) !I_RSTN |=> O_PAD_IO_OE_N)
    else $error("pad driven after reset");
  rx_reset_a: assert property (disable iff (1'b0) !I_RSTN |=> O_RX_DATA == 2'h0)
    else $error("received data not low after reset");
  ready_reset_a: assert property (disable iff (1'b0) !I_RSTN |=> !O_TX_READY)
    else $error("ready high in reset");
  oe_delay_a: assert property ($rose(I_OUT_EN) |-> O_PAD_IO_OE_N[*2] ##[1:2] !O_PAD_IO_OE_N)
    else $error("output enable delay wrong");
  oe_release_a: assert property ((!I_OUT_EN)[*4] |-> O_PAD_IO_OE_N)
    else $error("pad not released");
  neg_oe_a: assert property (O_PAD_IO_NEG_OE_N == O_PAD_IO_OE_N)
    else $error("negative leg enable differs");
  neg_data_a: assert property (!O_PAD_IO_OE_N |-> O_PAD_IO_NEG == !O_PAD_IO)
    else $error("negative leg not complement");
  rx_hold_a: assert property ((!I_IN_CLKEN)[*4] |-> $stable(O_RX_DATA))
    else $error("capture moved with enable low");
  ////////////////////////////////////////////////////////////////
  cover property (!O_PAD_IO_OE_N);
  cover property (I_TX_VALID && !O_TX_READY);
  cover property (O_RX_DATA == 2'h3);
endmodule // ddr_io_register_path_asserts

bind ddr_io_register_path ddr_io_register_path_asserts u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_OUT_EN(I_OUT_EN), .I_IN_CLKEN(I_IN_CLKEN),
  .I_TX_VALID(I_TX_VALID), .O_TX_READY(O_TX_READY), .O_PAD_IO(O_PAD_IO),
  .O_PAD_IO_OE_N(O_PAD_IO_OE_N), .O_PAD_IO_NEG(O_PAD_IO_NEG),
  .O_PAD_IO_NEG_OE_N(O_PAD_IO_NEG_OE_N), .O_RX_DATA(O_RX_DATA));

// ==== tb/tb_ddr_io_register_path.sv ====
// Self-checking bench for the pad register path
`timescale 1ns/1ps
module tb_ddr_io_register_path;
  logic clk, rstn, tx_valid, tx_ready, out_en, in_clken, out_clken, aclr, aset, sclr;
  logic ext_en, ext_val, line, line_n, pad_out, pad_out_n, pad_io, oe_n, pad_io_n, oe_n_n;
  logic [1:0] tx_data, rx_data;
  logic [1:0] words [8] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
  logic bits [$];
  logic ok, m;
  int bad_count, checks_done, i, j;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ddr_io_register_path u_dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_PAD_IN(line),
    .I_PAD_IN_NEG(line_n), .O_PAD_OUT(pad_out), .O_PAD_OUT_NEG(pad_out_n), .I_PAD_IO(line),
    .O_PAD_IO(pad_io), .O_PAD_IO_OE_N(oe_n), .I_PAD_IO_NEG(line_n), .O_PAD_IO_NEG(pad_io_n),
    .O_PAD_IO_NEG_OE_N(oe_n_n), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid),
    .O_TX_READY(tx_ready), .O_RX_DATA(rx_data), .I_OUT_EN(out_en), .I_IN_CLKEN(in_clken),
    .I_OUT_CLKEN(out_clken), .I_ACLR(aclr), .I_ASET(aset), .I_SCLR(sclr));
  pad_partner u_pad (.i_drv_oe_n(oe_n), .i_drv_val(pad_io), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_line(line), .o_line_n(line_n));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    #(25 * 400);
    bad_count++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn, tx_valid, out_en, in_clken, out_clken, aclr, aset, sclr, ext_en, ext_val} = '0;
    tx_data = 2'h0;
    cyc(4);
    chk({oe_n, tx_ready}, 2'h2);
    chk(rx_data, 2'h0);
    rstn = 1'b1;
    cyc(2);
    chk({1'b0, tx_ready}, 2'h1);
    for (i = 0; i < 12; i++) begin
      tx_data = words[i % 8];
      tx_valid = 1'b1;
      cyc(1);
    end
    tx_valid = 1'b0;
    chk({1'b0, tx_ready}, 2'h0);
    out_clken = 1'b1;
    out_en = 1'b1;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      if (!oe_n) bits.push_back(pad_io);
    end
    ok = 1'b0;
    for (i = 0; i + 16 <= bits.size(); i++) begin
      m = 1'b1;
      for (j = 0; j < 16; j++) if (bits[i + j] !== words[j / 2][1 - j % 2]) m = 1'b0;
      if (m) ok = 1'b1;
    end
    chk({1'b0, ok}, 2'h1);
    chk({1'b0, tx_ready}, 2'h1);
    out_en = 1'b0;
    ext_en = 1'b1;
    ext_val = 1'b1;
    in_clken = 1'b1;
    cyc(8);
    chk(rx_data, 2'h3);
    in_clken = 1'b0;
    ext_val = 1'b0;
    cyc(6);
    chk(rx_data, 2'h3);
    in_clken = 1'b1;
    cyc(6);
    chk(rx_data, 2'h0);
    give_verdict;
  end
endmodule // tb_ddr_io_register_path
